//--- core/sdac_defs.svh
// Purpose: constants for the delta-sigma converter control block
// Assumes: AXI4-Lite byte addresses, 32-bit data, 8-bit registers
// Notes: register values sit in the low byte of each word
//
// Behaviour
// - bypass buffer select drives buffer only while bypass path enabled.
// - input pair short bit joins the two selected inputs when set.
// - two-bit cross connect field at bits 5:4 steers inputs to amplifier.
// - three-bit offset select: 000/100 zero, others signed quarter steps.
// - negative selector picks pins, modulator, DAC, supply/6 or ground.
// - positive selector same map, modulator positive outputs, supply/5.
// - 24-bit result readable in three read-only byte registers.
// - high byte bits 23:16, middle 15:8, low 7:0.
// - divider field selects doubling factor and divide by 30 or 12.
// - factor 2 doubles sampled data; factor 1 is low latency.
// - oversampling code 0 gives 32768, halving per step to 128.
// - reference select: 0 external DAC reference, 1 internal regulator.
// - latch bit freezes results, no interrupt, completion flag unchanged.
// - completion flag 0 while converting, 1 when done, software clears.
// - soft reset holds filter reset, aborts result, no new conversion.
// - power-off bit resets to 1 and overrides sleep and soft reset.
// - sleep switches off all but amplifier and bandgap.
// - latch clock edge bit: 0 normal, 1 reversed polarity.
// - clock setup: codes up to 30 divide by 2(code+1), 31 undivided.
// - unimplemented register bits always read as zero.
// - each conversion end with latch, soft reset, sleep and power-off bits clear sets completion flag, raises interrupt request.
`ifndef SDAC_DEFS_SVH
`define SDAC_DEFS_SVH

`define SDAC_OFF_CONN 8'h00
`define SDAC_OFF_CHAN 8'h04
`define SDAC_OFF_RES_L 8'h08
`define SDAC_OFF_RES_M 8'h0c
`define SDAC_OFF_RES_H 8'h10
`define SDAC_OFF_RATE 8'h14
`define SDAC_OFF_PWR 8'h18
`define SDAC_OFF_CLK 8'h1c

`define SDAC_MASK_CONN 8'hfe
`define SDAC_MASK_CHAN 8'hff
`define SDAC_MASK_RATE 8'h7f
`define SDAC_MASK_PWR 8'hbf
`define SDAC_MASK_CLK 8'h1f

`define SDAC_RST_CONN 8'h00
`define SDAC_RST_CHAN 8'h00
`define SDAC_RST_RATE 8'h00
`define SDAC_RST_PWR 8'h04
`define SDAC_RST_CLK 8'h00

`define SDAC_BIT_REF 7
`define SDAC_BIT_LATCH 5
`define SDAC_BIT_EOC 4
`define SDAC_BIT_SRST 3
`define SDAC_BIT_OFF 2
`define SDAC_BIT_SLP 1
`define SDAC_BIT_EDGE 0
`define SDAC_BIT_BUF 7
`define SDAC_BIT_SHORT 6
`define SDAC_RATE_N12 5
`define SDAC_RATE_CHOP1 6

`define SDAC_MCLK_BYPASS 5'h1f
`define SDAC_N_LONG 5'd30
`define SDAC_N_SHORT 5'd12
`define SDAC_OSR_LOG2_MAX 5'd15
`define SDAC_OSR_CODE_MAX 4'h8
`define SDAC_RES_BITS 6'd24

`endif

//--- core/sdac_pkg.sv
// Purpose: shared types of the converter control block
// Assumes: constants live in sdac_defs.svh
// Notes: none
package sdac_pkg;
    typedef enum logic [1:0] {
        SDAC_CV_IDLE = 2'b01,
        SDAC_CV_RUN = 2'b10
    } sdac_cv_state_t;
    typedef enum logic [1:0] {
        SDAC_RESP_OKAY = 2'b00,
        SDAC_RESP_SLVERR = 2'b10
    } sdac_resp_t;
endpackage

//--- core/sdac_ctrl.sv
// Purpose: register file and conversion sequencing of the converter
// Assumes: modulator bitstream arrives asynchronously on i_mod_bit
// Notes: the filter is a plain ones counter scaled to 24 bits
`include "sdac_defs.svh"
module sdac_ctrl (
    input wire logic i_ref_clk,
    input wire logic i_reset,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic i_amp_bypass_enable,
    input wire logic i_mod_bit,
    output logic o_bypass_buffer_sel,
    output logic o_input_pair_short,
    output logic [1:0] o_input_cross_connect,
    output logic [2:0] o_offset_select,
    output logic [3:0] o_neg_input_select,
    output logic [3:0] o_pos_input_select,
    output logic o_pos_reference_sel,
    output logic o_latch_edge_rev,
    output logic o_amp_power_on,
    output logic o_mod_power_on,
    output logic o_filter_reset,
    output logic o_mod_clk_en,
    output logic o_conv_irq
);
    // register and bus state
    logic [7:0] conn_r, conn_nxt;
    logic [7:0] chan_r, chan_nxt;
    logic [7:0] rate_r, rate_nxt;
    logic [7:0] pwr_r, pwr_nxt;
    logic [7:0] clk_r, clk_nxt;
    logic [23:0] res_r, res_nxt;
    logic bvalid_r, bvalid_nxt;
    logic [1:0] bresp_r, bresp_nxt;
    logic rvalid_r, rvalid_nxt;
    logic [1:0] rresp_r, rresp_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic wr_ack_r, wr_ack_nxt;
    logic ar_ack_r, ar_ack_nxt;
    logic irq_r, irq_nxt;
    logic buf_r, buf_nxt;
    logic amp_on_r, amp_on_nxt;
    logic mod_on_r, mod_on_nxt;
    logic frst_r, frst_nxt;

    // conversion engine state
    sdac_pkg::sdac_cv_state_t st_r, st_nxt;
    logic mod_s1_r, mod_s2_r;
    logic [5:0] mclk_cnt_r, mclk_cnt_nxt;
    logic mclk_en_r, mclk_en_nxt;
    logic [4:0] n_cnt_r, n_cnt_nxt;
    logic adck_en_r, adck_en_nxt;
    logic [16:0] tick_r, tick_nxt;
    logic [16:0] ones_r, ones_nxt;
    logic srst_prev_r, srst_prev_nxt;
    logic done_r, done_nxt;
    logic [23:0] conv_r, conv_nxt;

    logic wr_go;
    logic rd_go;
    logic [7:0] wbyte;
    logic [4:0] lg;
    logic [4:0] osr_lg;
    logic [16:0] last_tick;
    logic [16:0] ones_f;
    logic [33:0] scaled;
    logic [5:0] sh;
    logic [5:0] mclk_top;
    logic [4:0] n_top;
    logic running;

    // a write is taken only with address and data offered together
    assign wr_go = s_axi_awvalid && s_axi_wvalid && !bvalid_r && !wr_ack_r;
    assign rd_go = s_axi_arvalid && !rvalid_r && !ar_ack_r;
    assign wbyte = s_axi_wdata[7:0];

    // bus and register group
    always_comb begin
        conn_nxt = conn_r;
        chan_nxt = chan_r;
        rate_nxt = rate_r;
        pwr_nxt = pwr_r;
        clk_nxt = clk_r;
        res_nxt = res_r;
        bvalid_nxt = bvalid_r;
        bresp_nxt = bresp_r;
        rvalid_nxt = rvalid_r;
        rresp_nxt = rresp_r;
        rdata_nxt = rdata_r;
        wr_ack_nxt = 1'b0;
        ar_ack_nxt = 1'b0;
        irq_nxt = 1'b0;
        if (bvalid_r && s_axi_bready) begin
            bvalid_nxt = 1'b0;
        end
        if (rvalid_r && s_axi_rready) begin
            rvalid_nxt = 1'b0;
        end
        if (wr_go) begin
            wr_ack_nxt = 1'b1;
            bvalid_nxt = 1'b1;
            bresp_nxt = sdac_pkg::SDAC_RESP_OKAY;
            // stored as written, reserved codes included
            unique case (s_axi_awaddr & 8'hfc)
                `SDAC_OFF_CONN: begin
                    if (s_axi_wstrb[0]) begin
                        conn_nxt = wbyte & `SDAC_MASK_CONN;
                    end
                end
                `SDAC_OFF_CHAN: begin
                    if (s_axi_wstrb[0]) begin
                        chan_nxt = wbyte & `SDAC_MASK_CHAN;
                    end
                end
                `SDAC_OFF_RATE: begin
                    if (s_axi_wstrb[0]) begin
                        rate_nxt = wbyte & `SDAC_MASK_RATE;
                    end
                end
                `SDAC_OFF_PWR: begin
                    if (s_axi_wstrb[0]) begin
                        pwr_nxt = wbyte & `SDAC_MASK_PWR;
                        // the flag only clears from software
                        pwr_nxt[`SDAC_BIT_EOC] = pwr_r[`SDAC_BIT_EOC]
                            & wbyte[`SDAC_BIT_EOC];
                    end
                end
                `SDAC_OFF_CLK: begin
                    if (s_axi_wstrb[0]) begin
                        clk_nxt = wbyte & `SDAC_MASK_CLK;
                    end
                end
                `SDAC_OFF_RES_L, `SDAC_OFF_RES_M, `SDAC_OFF_RES_H: begin
                end
                default: begin
                    bresp_nxt = sdac_pkg::SDAC_RESP_SLVERR;
                end
            endcase
        end
        // conversion end: set wins over a same-cycle software clear;
        // a result that ends as the filter is stopped is dropped
        if (done_r && running &&
            !pwr_r[`SDAC_BIT_LATCH]) begin
            res_nxt = conv_r;
            pwr_nxt[`SDAC_BIT_EOC] = 1'b1;
            irq_nxt = 1'b1;
        end
        if (rd_go) begin
            ar_ack_nxt = 1'b1;
            rvalid_nxt = 1'b1;
            rresp_nxt = sdac_pkg::SDAC_RESP_OKAY;
            rdata_nxt = 32'h0000_0000;
            // addr[1:0] are ignored; unmapped reads give zero data
            unique case (s_axi_araddr & 8'hfc)
                `SDAC_OFF_CONN: rdata_nxt[7:0] = conn_r;
                `SDAC_OFF_CHAN: rdata_nxt[7:0] = chan_r;
                `SDAC_OFF_RES_L: rdata_nxt[7:0] = res_r[7:0];
                `SDAC_OFF_RES_M: rdata_nxt[7:0] = res_r[15:8];
                `SDAC_OFF_RES_H: rdata_nxt[7:0] = res_r[23:16];
                `SDAC_OFF_RATE: rdata_nxt[7:0] = rate_r;
                `SDAC_OFF_PWR: rdata_nxt[7:0] = pwr_r;
                `SDAC_OFF_CLK: rdata_nxt[7:0] = clk_r;
                default: rresp_nxt = sdac_pkg::SDAC_RESP_SLVERR;
            endcase
        end
    end

    // analog control levels, registered
    always_comb begin
        buf_nxt = conn_r[`SDAC_BIT_BUF] & i_amp_bypass_enable;
        amp_on_nxt = !pwr_r[`SDAC_BIT_OFF];
        mod_on_nxt = !pwr_r[`SDAC_BIT_OFF] && !pwr_r[`SDAC_BIT_SLP];
        frst_nxt = !pwr_r[`SDAC_BIT_OFF] && pwr_r[`SDAC_BIT_SRST];
    end

    always_ff @(posedge i_ref_clk or posedge i_reset) begin
        if (i_reset) begin
            conn_r <= `SDAC_RST_CONN;
            chan_r <= `SDAC_RST_CHAN;
            rate_r <= `SDAC_RST_RATE;
            pwr_r <= `SDAC_RST_PWR;
            clk_r <= `SDAC_RST_CLK;
            res_r <= 24'h00_0000;
            bvalid_r <= 1'b0;
            bresp_r <= 2'b00;
            rvalid_r <= 1'b0;
            rresp_r <= 2'b00;
            rdata_r <= 32'h0000_0000;
            wr_ack_r <= 1'b0;
            ar_ack_r <= 1'b0;
            irq_r <= 1'b0;
            buf_r <= 1'b0;
            amp_on_r <= 1'b0;
            mod_on_r <= 1'b0;
            frst_r <= 1'b0;
        end else begin
            conn_r <= conn_nxt;
            chan_r <= chan_nxt;
            rate_r <= rate_nxt;
            pwr_r <= pwr_nxt;
            clk_r <= clk_nxt;
            res_r <= res_nxt;
            bvalid_r <= bvalid_nxt;
            bresp_r <= bresp_nxt;
            rvalid_r <= rvalid_nxt;
            rresp_r <= rresp_nxt;
            rdata_r <= rdata_nxt;
            wr_ack_r <= wr_ack_nxt;
            ar_ack_r <= ar_ack_nxt;
            irq_r <= irq_nxt;
            buf_r <= buf_nxt;
            amp_on_r <= amp_on_nxt;
            mod_on_r <= mod_on_nxt;
            frst_r <= frst_nxt;
        end
    end

    // rate derivation
    always_comb begin
        // reserved oversampling codes run at the shortest ratio
        if (rate_r[3:0] > `SDAC_OSR_CODE_MAX) begin
            osr_lg = 5'd7;
        end else begin
            osr_lg = `SDAC_OSR_LOG2_MAX - {1'b0, rate_r[3:0]};
        end
        // factor 2 doubles the samples per result
        lg = osr_lg + {4'h0, !rate_r[`SDAC_RATE_CHOP1]};
        last_tick = 17'((18'h1 << lg) - 18'h1);
        n_top = rate_r[`SDAC_RATE_N12] ? `SDAC_N_SHORT - 5'd1
                                       : `SDAC_N_LONG - 5'd1;
        mclk_top = 6'({clk_r[4:0], 1'b1});
        ones_f = ones_r + {16'h0000, mod_s2_r};
        sh = `SDAC_RES_BITS - {1'b0, lg};
        scaled = 34'(ones_f) << sh;
        running = !pwr_r[`SDAC_BIT_OFF] && !pwr_r[`SDAC_BIT_SLP] &&
                  !pwr_r[`SDAC_BIT_SRST];
    end

    // engine group
    always_comb begin
        st_nxt = st_r;
        mclk_cnt_nxt = mclk_cnt_r;
        mclk_en_nxt = 1'b0;
        n_cnt_nxt = n_cnt_r;
        adck_en_nxt = 1'b0;
        tick_nxt = tick_r;
        ones_nxt = ones_r;
        done_nxt = 1'b0;
        conv_nxt = conv_r;
        // only a high level seen while powered opens a start pulse
        srst_prev_nxt = pwr_r[`SDAC_BIT_SRST] && !pwr_r[`SDAC_BIT_OFF];
        // mclk enable every 2*(code+1) cycles, every cycle for code 31
        if (clk_r[4:0] == `SDAC_MCLK_BYPASS) begin
            mclk_en_nxt = 1'b1;
            mclk_cnt_nxt = 6'h00;
        end else if (mclk_cnt_r >= mclk_top) begin
            mclk_en_nxt = 1'b1;
            mclk_cnt_nxt = 6'h00;
        end else begin
            mclk_cnt_nxt = mclk_cnt_r + 6'h01;
        end
        // converter tick once per N mclk enables
        if (mclk_en_r) begin
            if (n_cnt_r >= n_top) begin
                n_cnt_nxt = 5'h00;
                adck_en_nxt = 1'b1;
            end else begin
                n_cnt_nxt = n_cnt_r + 5'h01;
            end
        end
        unique case (st_r)
            sdac_pkg::SDAC_CV_IDLE: begin
                tick_nxt = 17'h0_0000;
                ones_nxt = 17'h0_0000;
                // falling soft reset while powered starts conversions
                if (srst_prev_r && !pwr_r[`SDAC_BIT_SRST] &&
                    !pwr_r[`SDAC_BIT_OFF]) begin
                    st_nxt = sdac_pkg::SDAC_CV_RUN;
                end
            end
            sdac_pkg::SDAC_CV_RUN: begin
                if (pwr_r[`SDAC_BIT_OFF] || pwr_r[`SDAC_BIT_SRST]) begin
                    // abort the partial result
                    st_nxt = sdac_pkg::SDAC_CV_IDLE;
                    tick_nxt = 17'h0_0000;
                    ones_nxt = 17'h0_0000;
                end else if (running && adck_en_r) begin
                    if (tick_r >= last_tick) begin
                        tick_nxt = 17'h0_0000;
                        ones_nxt = 17'h0_0000;
                        done_nxt = 1'b1;
                        // a full-scale count overflows 24 bits: clamp
                        if (scaled[33:24] != 10'h000) begin
                            conv_nxt = 24'hff_ffff;
                        end else begin
                            conv_nxt = scaled[23:0];
                        end
                    end else begin
                        tick_nxt = tick_r + 17'h0_0001;
                        ones_nxt = ones_f;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge i_ref_clk or posedge i_reset) begin
        if (i_reset) begin
            st_r <= sdac_pkg::SDAC_CV_IDLE;
            mod_s1_r <= 1'b0;
            mod_s2_r <= 1'b0;
            mclk_cnt_r <= 6'h00;
            mclk_en_r <= 1'b0;
            n_cnt_r <= 5'h00;
            adck_en_r <= 1'b0;
            tick_r <= 17'h0_0000;
            ones_r <= 17'h0_0000;
            srst_prev_r <= 1'b0;
            done_r <= 1'b0;
            conv_r <= 24'h00_0000;
        end else begin
            st_r <= st_nxt;
            mod_s1_r <= i_mod_bit;
            mod_s2_r <= mod_s1_r;
            mclk_cnt_r <= mclk_cnt_nxt;
            mclk_en_r <= mclk_en_nxt;
            n_cnt_r <= n_cnt_nxt;
            adck_en_r <= adck_en_nxt;
            tick_r <= tick_nxt;
            ones_r <= ones_nxt;
            srst_prev_r <= srst_prev_nxt;
            done_r <= done_nxt;
            conv_r <= conv_nxt;
        end
    end

    assign s_axi_awready = wr_ack_r;
    assign s_axi_wready = wr_ack_r;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_arready = ar_ack_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rresp = rresp_r;
    assign s_axi_rdata = rdata_r;
    assign o_bypass_buffer_sel = buf_r;
    assign o_input_pair_short = conn_r[`SDAC_BIT_SHORT];
    assign o_input_cross_connect = conn_r[5:4];
    assign o_offset_select = conn_r[3:1];
    assign o_neg_input_select = chan_r[7:4];
    assign o_pos_input_select = chan_r[3:0];
    assign o_pos_reference_sel = pwr_r[`SDAC_BIT_REF];
    assign o_latch_edge_rev = pwr_r[`SDAC_BIT_EDGE];
    assign o_amp_power_on = amp_on_r;
    assign o_mod_power_on = mod_on_r;
    assign o_filter_reset = frst_r;
    assign o_mod_clk_en = adck_en_r;
    assign o_conv_irq = irq_r;
endmodule

//--- dv/sdac_ctrl_asserts.sv
// Purpose: port checks of the converter control block
// Assumes: sees only the sdac_ctrl ports
// Notes: bound to every sdac_ctrl instance
module sdac_ctrl_asserts (
    input wire logic i_ref_clk,
    input wire logic i_reset,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic [31:0] s_axi_rdata,
    input wire logic i_amp_bypass_enable,
    input wire logic o_bypass_buffer_sel,
    input wire logic o_amp_power_on,
    input wire logic o_mod_power_on,
    input wire logic o_filter_reset,
    input wire logic o_mod_clk_en,
    input wire logic o_conv_irq
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_reset);
    a_buf_gated: assert property (
        o_bypass_buffer_sel |-> $past(i_amp_bypass_enable))
        else $error("buffer select without bypass path");
    a_off_overrides: assert property (
        !o_amp_power_on |-> !o_mod_power_on && !o_filter_reset)
        else $error("power off not overriding");
    a_irq_single: assert property (
        o_conv_irq |=> !o_conv_irq)
        else $error("irq longer than one cycle");
    a_irq_needs_run: assert property (
        o_conv_irq |-> o_mod_power_on && !o_filter_reset)
        else $error("irq while filter held or off");
    a_tick_single: assert property (
        o_mod_clk_en |=> !o_mod_clk_en)
        else $error("tick longer than one cycle");
    a_write_answer: assert property (
        s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid && !s_axi_awready
        |=> s_axi_awready && s_axi_wready && s_axi_bvalid)
        else $error("write not answered next cycle");
    a_wr_pulse: assert property (
        s_axi_awready |=> !s_axi_awready)
        else $error("awready held");
    a_read_answer: assert property (
        s_axi_arvalid && !s_axi_rvalid && !s_axi_arready
        |=> s_axi_arready && s_axi_rvalid)
        else $error("read not answered next cycle");
    a_rdata_upper: assert property (
        s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
        else $error("upper read bits not zero");
    c_irq: cover property (o_conv_irq);
    c_frst: cover property (o_filter_reset);
    c_slverr: cover property (s_axi_bvalid && s_axi_bresp == 2'b10);
endmodule
bind sdac_ctrl sdac_ctrl_asserts i_sdac_ctrl_asserts (.*);

//--- dv/sdac_mod_model.sv
// Purpose: modulator bitstream feeding the converter control block
// Assumes: one new bit per converter clock tick
// Notes: alternating stream is half scale, ones mode is full scale
module sdac_mod_model (
    input wire logic i_ref_clk,
    input wire logic i_reset,
    input wire logic i_tick,
    input wire logic i_all_ones,
    output logic o_bit
);
    timeunit 1ns;
    timeprecision 1ps;
    always_ff @(posedge i_ref_clk or posedge i_reset) begin
        if (i_reset) begin
            o_bit <= 1'b0;
        end else if (i_tick) begin
            o_bit <= i_all_ones | ~o_bit;
        end
    end
endmodule

//--- dv/tb.sv
// Purpose: register and conversion tests of sdac_ctrl
// Assumes: AXI4-Lite master tasks, values sampled at the edge
// Notes: fastest clock setup keeps conversions short
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_ref_clk, i_reset, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_rready, i_amp_bypass_enable, i_mod_bit, ones;
    logic [7:0] s_axi_awaddr, s_axi_araddr, d;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb, o_neg_input_select, o_pos_input_select;
    logic [1:0] s_axi_bresp, s_axi_rresp, o_input_cross_connect;
    logic [2:0] o_offset_select;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, o_bypass_buffer_sel, o_input_pair_short;
    logic o_pos_reference_sel, o_latch_edge_rev, o_amp_power_on;
    logic o_mod_power_on, o_filter_reset, o_mod_clk_en, o_conv_irq;
    int miscompares, check_count;
    logic [7:0] ra[5] = '{8'h00, 8'h04, 8'h14, 8'h18, 8'h1c};
    logic [7:0] rv[5] = '{8'h00, 8'h00, 8'h00, 8'h04, 8'h00};
    logic [3:0] cc[10] = '{4'h0, 4'h1, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9,
        4'ha, 4'hf};
    logic [7:0] pc[8] = '{8'h1f, 8'h1f, 8'h00, 8'h02, 8'h1e, 8'h1f,
        8'h1f, 8'h1f};
    logic [7:0] pr[8] = '{8'h68, 8'h48, 8'h68, 8'h28, 8'h08, 8'h68,
        8'h28, 8'h67};
    int pn[8] = '{12, 30, 24, 72, 1860, 1536, 3072, 3072};
    sdac_ctrl i_sdac_ctrl (.*);
    sdac_mod_model i_sdac_mod_model (.i_ref_clk(i_ref_clk),
        .i_reset(i_reset), .i_tick(o_mod_clk_en), .i_all_ones(ones),
        .o_bit(i_mod_bit));
    initial begin
        i_ref_clk = 1'b0;
        forever #5 i_ref_clk = ~i_ref_clk;
    end
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] s);
        check_count++;
        if (s !== e) begin
            $display("[FAIL] %s expected %h seen %h", nm, e, s);
            miscompares++;
        end
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic hang();
        miscompares++;
        $display("[FAIL] wait expected answer seen none");
        close_out();
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v,
                      input logic [1:0] er = 2'b00,
                      input logic [3:0] st = 4'h1);
        int n;
        n = 0;
        @(posedge i_ref_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, v};
        s_axi_wstrb <= st;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge i_ref_clk);
            n++;
        end while (s_axi_awready !== 1'b1 && n < 99);
        s_axi_awvalid <= 1'b0;
        s_axi_wvalid <= 1'b0;
        while (s_axi_bvalid !== 1'b1 && n < 99) begin
            @(posedge i_ref_clk);
            n++;
        end
        s_axi_bready <= 1'b0;
        if (n >= 99) hang();
        chk("bresp", er, s_axi_bresp);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e,
                      input logic [1:0] er = 2'b00);
        int n;
        n = 0;
        @(posedge i_ref_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge i_ref_clk);
            n++;
        end while (s_axi_arready !== 1'b1 && n < 99);
        s_axi_arvalid <= 1'b0;
        while (s_axi_rvalid !== 1'b1 && n < 99) begin
            @(posedge i_ref_clk);
            n++;
        end
        s_axi_rready <= 1'b0;
        if (n >= 99) hang();
        chk($sformatf("rdata %h", a), {24'h0, e}, s_axi_rdata);
        chk("rresp", er, s_axi_rresp);
    endtask
    task automatic res(input logic [23:0] e);
        rd(8'h10, e[23:16]);
        rd(8'h0c, e[15:8]);
        rd(8'h08, e[7:0]);
    endtask
    task automatic wirq(input int lim, input logic e);
        logic seen;
        seen = 1'b0;
        repeat (lim) begin
            @(posedge i_ref_clk);
            if (o_conv_irq === 1'b1) seen = 1'b1;
            if (seen && e) break;
        end
        chk("irq", e, seen);
        if (e && !seen) hang();
    endtask
    // gap between pulses of tick or irq, first gap skipped after a change
    task automatic per(input int e, input logic w);
        int n;
        n = 0;
        while ((w ? o_conv_irq : o_mod_clk_en) !== 1'b1 && n < 9000) begin
            @(posedge i_ref_clk);
            n++;
        end
        repeat (2) begin
            n = 0;
            do begin
                @(posedge i_ref_clk);
                n++;
            end while ((w ? o_conv_irq : o_mod_clk_en) !== 1'b1 && n < 9000);
        end
        chk(w ? "irq gap" : "tick gap", e, n);
        if (n >= 9000) hang();
    endtask
    initial begin
        i_reset = 1'b1;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
        {s_axi_rready, i_amp_bypass_enable, ones} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
        repeat (10) @(posedge i_ref_clk);
        i_reset <= 1'b0;
        foreach (ra[i]) rd(ra[i], rv[i]);
        rd(8'h20, 8'h00, 2'b10);
        wr(8'h20, 8'hff, 2'b10);
        $display("test reset and map done");
        for (int i = 0; i < 8; i++) begin
            d = {i[0], i[1], i[2:1], i[2:0], 1'b1};
            wr(8'h00, d);
            rd(8'h00, d & 8'hfe);
            chk("pair short", d[6], o_input_pair_short);
            chk("cross", d[5:4], o_input_cross_connect);
            chk("offset", d[3:1], o_offset_select);
        end
        foreach (cc[i]) begin
            wr(8'h04, {cc[i], ~cc[i]});
            rd(8'h04, {cc[i], ~cc[i]});
            chk("neg sel", cc[i], o_neg_input_select);
            chk("pos sel", 4'(~cc[i]), o_pos_input_select);
        end
        chk("buf sel", 1'b0, o_bypass_buffer_sel);
        i_amp_bypass_enable <= 1'b1;
        repeat (3) @(posedge i_ref_clk);
        chk("buf sel", 1'b1, o_bypass_buffer_sel);
        wr(8'h14, 8'hff);
        rd(8'h14, 8'h7f);
        wr(8'h1c, 8'hff);
        wr(8'h1c, 8'h00, 2'b00, 4'h0);
        rd(8'h1c, 8'h1f);
        wr(8'h18, 8'hff);
        rd(8'h18, 8'haf);
        chk("ref sel", 1'b1, o_pos_reference_sel);
        chk("edge rev", 1'b1, o_latch_edge_rev);
        chk("amp on", 1'b0, o_amp_power_on);
        chk("filter rst", 1'b0, o_filter_reset);
        wr(8'h18, 8'h02);
        rd(8'h18, 8'h02);
        chk("amp on", 1'b1, o_amp_power_on);
        chk("mod on", 1'b0, o_mod_power_on);
        $display("test registers done");
        wr(8'h14, 8'h68);
        wr(8'h18, 8'h08);
        rd(8'h18, 8'h08);
        chk("filter rst", 1'b1, o_filter_reset);
        wr(8'h18, 8'h00);
        rd(8'h18, 8'h00);
        chk("mod on", 1'b1, o_mod_power_on);
        wirq(3000, 1'b1);
        rd(8'h18, 8'h10);
        wr(8'h18, 8'h20);
        ones <= 1'b1;
        res(24'h800000);
        wirq(4000, 1'b0);
        rd(8'h18, 8'h20);
        wr(8'h10, 8'h55);
        res(24'h800000);
        wr(8'h18, 8'h00);
        wirq(3000, 1'b1);
        res(24'hffffff);
        $display("test conversion and latch done");
        wr(8'h18, 8'h08);
        wirq(3500, 1'b0);
        wr(8'h18, 8'h0c);
        rd(8'h18, 8'h0c);
        chk("filter rst", 1'b0, o_filter_reset);
        wr(8'h18, 8'h08);
        wr(8'h18, 8'h00);
        foreach (pc[i]) begin
            wr(8'h1c, pc[i]);
            wr(8'h14, pr[i]);
            per(pn[i], i > 4);
        end
        wr(8'h18, 8'h04);
        rd(8'h18, 8'h04);
        chk("amp on", 1'b0, o_amp_power_on);
        wirq(2000, 1'b0);
        $display("test rates done");
        close_out();
    end
endmodule
